// file: shared/txc_pkg.sv
// Notes on behaviour
// - Status flush clears status pointers, self-clears
// - Data flush clears data pointers, self-clears
// - Full status FIFO suspends unless overrun allowed
// - Status full event ignores overrun allow
// - Enabled transmitter sends queued frame data
// - Enable clears itself after completed halt
// - Halt finishes current frame, then self-clears
// - Halt bit writes ignored while it is set
// - Mode bit picks threshold table, unless forwarding
// - Store-forward waits for whole frame
// - Otherwise start at selected threshold level
// - Threshold mode reports data underrun
// - Allotment sets transmit space, 1KB units, max 14
// - Status takes 512 bytes, data the rest
// - Data FIFO holds commands and frame data
// - Receive side gets 16KB minus allotment
// - Transmit control bits reset to zero
package txc_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_TX_CTRL = 8'h70;
   localparam logic [7:0] ADDR_HW_SETUP = 8'h74;
   localparam logic [7:0] ADDR_TX_STAT = 8'h78;

   localparam int BIT_STAT_FLUSH = 15;
   localparam int BIT_DATA_FLUSH = 14;
   localparam int BIT_OVR_ALLOW = 2;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_HALT = 0;
   localparam int BIT_THR_MODE = 21;
   localparam int BIT_STORE_FWD = 20;
   localparam int LSB_ALLOT = 16;
   localparam int LSB_LAUNCH = 12;
   localparam int BIT_UNDERRUN = 0;
   localparam int BIT_STAT_FULL = 1;
   localparam int BIT_STOPPED = 2;

   // ****************************************************************
   // Reset values and sizes
   // ****************************************************************
   localparam logic [3:0] ALLOT_RST = 4'h5;
   localparam logic [3:0] ALLOT_MAX = 4'he;
   localparam logic [3:0] ALLOT_MIN = 4'h2;
   localparam logic [14:0] STAT_BYTES = 15'h0200;
   localparam logic [15:0] TOTAL_BYTES = 16'h4000;
   localparam int KB_SHIFT = 10;

   // Start thresholds in words, entry n at bits 8n+7:8n
   localparam logic [31:0] THR_TABLE_FAST = 32'h28201812;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic busy;
      logic word_req;
      logic stat_full;
      logic frame_complete;
      logic [11:0] data_words;
   } txc_mac_s;

   typedef struct packed {
      logic stat_ptr_clear;
      logic data_ptr_clear;
      logic launch_ok;
      logic tx_enabled;
      logic underrun;
      logic stat_full_event;
      logic [7:0] thr_words;
      logic [14:0] data_bytes;
      logic [14:0] rx_bytes;
   } txc_ctl_s;

endpackage

// file: core/txc_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module txc_top #(
   parameter int WORDS_W = 12,
   parameter logic [31:0] THR_TABLE_SLOW = 32'h60504020
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transmit engine side
   input wire txc_pkg::txc_mac_s mac,
   output txc_pkg::txc_ctl_s ctl
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (WORDS_W != 12) begin : g_chk
      $error("txc_top: WORDS_W must match the carrier width of 12");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic stat_flush;
      logic data_flush;
      logic ovr_allow;
      logic enable;
      logic halt;
      logic thr_mode;
      logic store_fwd;
      logic [3:0] allot;
      logic [1:0] launch;
      logic underrun_flag;
      logic full_d;
      logic stopped;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic launch_ok;
      logic underrun;
      logic full_event;
      logic [7:0] thr;
      logic [14:0] data_bytes;
      logic [14:0] rx_bytes;
   } txc_state_s;

   txc_state_s st;
   txc_state_s next_st;

   logic setup;
   logic wr_do;
   logic hit_ctrl;
   logic hit_hw;
   logic hit_stat;
   logic [31:0] rd_val;
   logic [3:0] eff_allot;
   logic [15:0] tx_bytes;
   logic [7:0] thr_sel;
   logic halt_done;
   logic start_ok;

   assign setup = psel & ~penable;
   assign wr_do = psel & penable & pwrite & st.rdy;
   assign hit_ctrl = (paddr == txc_pkg::ADDR_TX_CTRL);
   assign hit_hw = (paddr == txc_pkg::ADDR_HW_SETUP);
   assign hit_stat = (paddr == txc_pkg::ADDR_TX_STAT);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      rd_val = 32'h0;
      eff_allot = 4'h0;
      tx_bytes = 16'h0;
      thr_sel = 8'h0;
      halt_done = 1'b0;
      start_ok = 1'b0;

      // Flush requests live for exactly one cycle
      next_st.stat_flush = 1'b0;
      next_st.data_flush = 1'b0;
      next_st.underrun = 1'b0;
      next_st.full_event = 1'b0;
      next_st.full_d = mac.stat_full;

      // Full event is independent of the overrun allow bit
      if (mac.stat_full && !st.full_d) begin
         next_st.full_event = 1'b1;
      end

      // Halt completes only once no frame is running or starting
      halt_done = st.halt && !st.launch_ok && !mac.busy;
      if (halt_done) begin
         next_st.halt = 1'b0;
         next_st.enable = 1'b0;
         next_st.stopped = 1'b1;
      end

      // Starving the engine mid-frame is an underrun
      if (!st.store_fwd && mac.busy && mac.word_req
          && (mac.data_words == 12'h000)) begin
         next_st.underrun = 1'b1;
      end

      // Register reads, captured in the setup cycle
      rd_val[txc_pkg::BIT_STAT_FLUSH] = 1'b0;
      if (hit_ctrl) begin
         // Flushes act at once, so a back-to-back read never sees them
         rd_val[txc_pkg::BIT_STAT_FLUSH] = 1'b0;
         rd_val[txc_pkg::BIT_DATA_FLUSH] = 1'b0;
         rd_val[txc_pkg::BIT_OVR_ALLOW] = st.ovr_allow;
         rd_val[txc_pkg::BIT_ENABLE] = st.enable;
         rd_val[txc_pkg::BIT_HALT] = st.halt;
      end else if (hit_hw) begin
         rd_val[txc_pkg::BIT_THR_MODE] = st.thr_mode;
         rd_val[txc_pkg::BIT_STORE_FWD] = st.store_fwd;
         rd_val[txc_pkg::LSB_ALLOT +: 4] = st.allot;
         rd_val[txc_pkg::LSB_LAUNCH +: 2] = st.launch;
      end else if (hit_stat) begin
         rd_val[txc_pkg::BIT_UNDERRUN] = st.underrun_flag;
         rd_val[txc_pkg::BIT_STAT_FULL] = mac.stat_full;
         rd_val[txc_pkg::BIT_STOPPED] = st.stopped;
      end

      // One wait-free access phase: ready rises at the setup edge
      next_st.rdy = setup;
      next_st.err = setup & ~(hit_ctrl | hit_hw | hit_stat);
      if (setup) begin
         next_st.rdata = pwrite ? 32'h0 : rd_val;
      end

      // Writes take effect at the access edge; reserved bits dropped
      if (wr_do && hit_ctrl) begin
         next_st.stat_flush = pwdata[txc_pkg::BIT_STAT_FLUSH];
         next_st.data_flush = pwdata[txc_pkg::BIT_DATA_FLUSH];
         next_st.ovr_allow = pwdata[txc_pkg::BIT_OVR_ALLOW];
         // A host set of enable wins over a completing halt
         if (pwdata[txc_pkg::BIT_ENABLE]) begin
            next_st.enable = 1'b1;
            next_st.stopped = 1'b0;
         end else begin
            next_st.enable = 1'b0;
         end
         if (!st.halt && pwdata[txc_pkg::BIT_HALT]) begin
            next_st.halt = 1'b1;
            next_st.stopped = 1'b0;
         end
      end
      if (wr_do && hit_hw) begin
         next_st.thr_mode = pwdata[txc_pkg::BIT_THR_MODE];
         next_st.store_fwd = pwdata[txc_pkg::BIT_STORE_FWD];
         next_st.allot = pwdata[txc_pkg::LSB_ALLOT +: 4];
         next_st.launch = pwdata[txc_pkg::LSB_LAUNCH +: 2];
      end
      // Write one to clear; a fresh underrun wins over the clear
      if (wr_do && hit_stat && pwdata[txc_pkg::BIT_UNDERRUN]) begin
         next_st.underrun_flag = 1'b0;
      end
      if (next_st.underrun) begin
         next_st.underrun_flag = 1'b1;
      end

      // Split of the shared buffer, clamped to the legal range
      if (next_st.allot > txc_pkg::ALLOT_MAX) begin
         eff_allot = txc_pkg::ALLOT_MAX;
      end else if (next_st.allot < txc_pkg::ALLOT_MIN) begin
         eff_allot = txc_pkg::ALLOT_MIN;
      end else begin
         eff_allot = next_st.allot;
      end
      tx_bytes = 16'({12'h0, eff_allot} << txc_pkg::KB_SHIFT);
      // Data space also carries the command words
      next_st.data_bytes =
         15'(tx_bytes - {1'b0, txc_pkg::STAT_BYTES});
      next_st.rx_bytes = 15'(txc_pkg::TOTAL_BYTES - tx_bytes);

      // Threshold table lookup
      if (next_st.thr_mode) begin
         thr_sel = THR_TABLE_SLOW[{next_st.launch, 3'b000} +: 8];
      end else begin
         thr_sel = txc_pkg::THR_TABLE_FAST[{next_st.launch, 3'b000} +: 8];
      end
      next_st.thr = thr_sel;

      // Frame start permission, from the values about to be held
      if (next_st.store_fwd) begin
         start_ok = mac.frame_complete;
      end else begin
         start_ok = mac.frame_complete
            || (mac.data_words >= {4'h0, thr_sel});
      end
      next_st.launch_ok = next_st.enable && !next_st.halt
         && (next_st.ovr_allow || !mac.stat_full)
         && start_ok;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.allot <= txc_pkg::ALLOT_RST;
         st.data_bytes <= 15'h1200;
         st.rx_bytes <= 15'h2c00;
         st.thr <= 8'h12;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs, all straight from state
   // ****************************************************************
   assign prdata = st.rdata;
   assign pready = st.rdy;
   assign pslverr = st.err;
   assign ctl.stat_ptr_clear = st.stat_flush;
   assign ctl.data_ptr_clear = st.data_flush;
   assign ctl.launch_ok = st.launch_ok;
   assign ctl.tx_enabled = st.enable;
   assign ctl.underrun = st.underrun;
   assign ctl.stat_full_event = st.full_event;
   assign ctl.thr_words = st.thr;
   assign ctl.data_bytes = st.data_bytes;
   assign ctl.rx_bytes = st.rx_bytes;

endmodule

// file: sim/txc_props.sv
`timescale 1ns/100ps
module txc_props (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Engine side
   input wire txc_pkg::txc_mac_s mac,
   input wire txc_pkg::txc_ctl_s ctl
);
   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_ctrl;
   assign wr_ctrl = pready && pwrite && paddr == 8'h70;
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("ready late");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_unmapped: assert property (pready |->
      pslverr == !(paddr inside {8'h70, 8'h74, 8'h78}))
      else $error("slave error wrong");
   a_ctrl_reserved: assert property (
      pready && !pwrite && paddr == 8'h70 |-> prdata[31:3] == 29'h0)
      else $error("control reads nonzero");
   a_stat_flush: assert property (
      wr_ctrl && pwdata[15] |=> ctl.stat_ptr_clear)
      else $error("status flush missing");
   a_data_flush: assert property (
      wr_ctrl && pwdata[14] |=> ctl.data_ptr_clear)
      else $error("data flush missing");
   a_flush_cause: assert property (
      ctl.stat_ptr_clear || ctl.data_ptr_clear
      |-> $past(wr_ctrl && (pwdata[15] || pwdata[14])))
      else $error("flush without write");
   a_full_event: assert property (
      $rose(mac.stat_full) |=> ctl.stat_full_event)
      else $error("full event missing");
   a_underrun_cause: assert property (ctl.underrun |->
      $past(mac.busy && mac.word_req && mac.data_words == 12'h000))
      else $error("underrun without cause");
   a_space_split: assert property (
      {1'b0, ctl.data_bytes} + {1'b0, ctl.rx_bytes} == 16'h3e00)
      else $error("buffer split wrong");
   c_enable: cover property (wr_ctrl && pwdata[1]);
   c_underrun: cover property (ctl.underrun);
   c_refused: cover property (pready && pslverr);
endmodule

// file: sim/txc_engine_model.sv
`timescale 1ns/100ps
module txc_engine_model (
   // Clock, reset and scenario knobs
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] load,
   input wire logic full,
   // Block side
   input wire txc_pkg::txc_ctl_s ctl,
   output txc_pkg::txc_mac_s mac
);
   // ****************************************************************
   // Frames of 24 word requests, so a 20 word load runs dry
   // ****************************************************************
   int left;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac <= '0;
         left <= 0;
      end else begin
         mac.stat_full <= full;
         mac.frame_complete <= mac.data_words >= 12'h018;
         if (ctl.data_ptr_clear)
            mac.data_words <= 12'h000;
         else if (load != 12'h000)
            mac.data_words <= load;
         else if (mac.word_req && mac.data_words != 12'h000)
            mac.data_words <= mac.data_words - 12'h001;
         if (left == 0 && ctl.launch_ok)
            left <= 24;
         else if (left != 0)
            left <= left - 1;
         mac.busy <= left > 1 || (left == 0 && ctl.launch_ok);
         mac.word_req <= left > 1 || (left == 0 && ctl.launch_ok);
      end
   end
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, full, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv, lf, v;
   logic [11:0] load;
   txc_pkg::txc_mac_s mac;
   txc_pkg::txc_ctl_s ctl;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int al, n;
   int fast[4] = '{18, 24, 32, 40};
   int slow[4] = '{32, 64, 80, 96};
   txc_top txc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac(mac),
      .ctl(ctl));
   txc_engine_model txc_engine_model_inst (.pclk(pclk), .presetn(presetn),
      .load(load), .full(full), .ctl(ctl), .mac(mac));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // A hung handshake ends here rather than stalling the run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         close_out();
      end
   end
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv & m, e);
   endtask
   task automatic wb(input logic b);
      n = 0;
      while (mac.busy !== b && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk(mac.busy, b);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************************************************************
   // Stimulus
   // ****************************************************************
   initial begin
      {psel, penable, pwrite, full, presetn} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      load = 12'h000;
      lf = 32'h0000b4d5;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h70, 32'hffffffff, 32'h0);
      rd(8'h74, 32'hffffffff, 32'h00050000);
      chk(ctl.thr_words, fast[0]);
      apb(1'b0, 8'h7c, 32'h0);
      chk(rv, 32'h0);
      chk(err, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         lf = nx(lf);
         al = 2 + lf[7:0] % 13;
         v = {lf[31:21], 1'b0, al[3:0], lf[15:0]};
         apb(1'b1, 8'h74, v);
         rd(8'h74, 32'hffffffff, v & 32'h003f3000);
         chk(ctl.thr_words,
             v[21] ? slow[v[13:12]] : fast[v[13:12]]);
         chk(ctl.data_bytes, al * 1024 - 512);
         chk(ctl.rx_bytes, 16384 - al * 1024);
      end
      $display("test split done");
      load <= 12'h00a;
      apb(1'b1, 8'h70, 32'h0000c000);
      load <= 12'h000;
      rd(8'h70, 32'hffffffff, 32'h0);
      chk(mac.data_words, 32'h0);
      apb(1'b1, 8'h74, 32'h00050000);
      load <= 12'h014;
      apb(1'b1, 8'h70, 32'h2);
      load <= 12'h000;
      wb(1'b1);
      chk(ctl.tx_enabled, 1'b1);
      apb(1'b1, 8'h70, 32'h3);
      rd(8'h70, 32'hffffffff, 32'h3);
      apb(1'b1, 8'h70, 32'h2);
      rd(8'h70, 32'hffffffff, 32'h3);
      wb(1'b0);
      rd(8'h70, 32'hffffffff, 32'h0);
      chk(ctl.tx_enabled, 1'b0);
      rd(8'h78, 32'h5, 32'h5);
      apb(1'b1, 8'h78, 32'h1);
      rd(8'h78, 32'h1, 32'h0);
      $display("test halt done");
      full <= 1'b1;
      load <= 12'h014;
      apb(1'b1, 8'h70, 32'h2);
      load <= 12'h000;
      rd(8'h78, 32'h2, 32'h2);
      chk(mac.busy, 1'b0);
      apb(1'b1, 8'h70, 32'h6);
      wb(1'b1);
      $display("test full done");
      // Store and forward: a short partial frame must not launch
      wb(1'b0);
      apb(1'b1, 8'h74, 32'h00150000);
      load <= 12'h014;
      repeat (6) @(posedge pclk);
      chk(mac.busy, 1'b0);
      load <= 12'h018;
      @(posedge pclk);
      load <= 12'h000;
      wb(1'b1);
      $display("test store done");
      close_out();
   end
endmodule
bind txc_top txc_props txc_props_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .mac(mac), .ctl(ctl));
